/* File: cpm_pkg.sv */
// Constants, types and carriers shared by the counter period and position meter.
// Operation
// [RULE_01] Period mode measures one gate period once armed
// [RULE_02] Gate active edge selectable, rising or falling
// [RULE_03] Count selected source edges during the period
// [RULE_04] No position counting before the counter is armed
// [RULE_05] Position read on demand or sample clocked
// [RULE_06] Quadrature one, two, four counts; two-pulse too
// [RULE_07] Encoder channels A, B and optional index Z
// [RULE_08] Single count: A leads, increment on A rise
// [RULE_09] Single count: B leads, decrement on A fall
// [RULE_10] Double count: step on both A edges
// [RULE_11] Quadruple count: step on every A, B edge
// [RULE_12] Index high in chosen phase reloads the count
// [RULE_13] Count step first, then reload, then resume
// [RULE_14] Two-pulse: A rise increments, B rise decrements
// [RULE_15] Sample edge captures count without clearing it
// [RULE_16] Synchronise inputs and detect edges before decoding
// [RULE_17] Each arm clears the count to zero
package cpm_pkg;

    // ----------------------------------------------------------------
    // Widths and input indices
    // ----------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int N_IN = 5;
    localparam int IX_GATE = 0;
    localparam int IX_SRC = 1;
    localparam int IX_A = 2;
    localparam int IX_B = 3;
    localparam int IX_Z = 4;
    localparam int BUF_N = 2;

    localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [N_IN-1:0] IN_ZERO = {N_IN{1'b0}};

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_MEAS = 2'h3,
        ST_DONE = 2'h2
    } cpm_state_t;

    typedef enum logic [1:0] {
        DEC_X1 = 2'h0,
        DEC_X2 = 2'h1,
        DEC_X4 = 2'h2,
        DEC_TWO = 2'h3
    } cpm_decode_t;

    typedef enum logic {
        MODE_PERIOD = 1'b0,
        MODE_POS = 1'b1
    } cpm_mode_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // Phase for index reload is {A,B} levels
    typedef struct packed {
        cpm_mode_t mode;
        logic gate_fall;
        logic src_fall;
        logic sample_fall;
        cpm_decode_t decode;
        logic buffered;
        logic z_enable;
        logic [1:0] z_phase;
        logic [CNT_W-1:0] reload;
    } cpm_cfg_t;

    typedef struct packed {
        logic [N_IN-1:0] lvl;
        logic [N_IN-1:0] rise;
        logic [N_IN-1:0] fall;
    } cpm_edges_t;

    typedef struct packed {
        logic [N_IN-1:0] s1;
        logic [N_IN-1:0] s2;
        logic [N_IN-1:0] s3;
        logic [N_IN-1:0] lvl;
    } cpm_sync_t;

    typedef struct packed {
        cpm_state_t state;
        logic busy;
        logic done;
        logic ovr;
        logic [CNT_W-1:0] cnt;
        logic [BUF_N-1:0] v;
        logic [BUF_N-1:0][CNT_W-1:0] ent;
    } cpm_core_t;

    localparam cpm_sync_t SYNC_RST = '{s1: IN_ZERO, s2: IN_ZERO, s3: IN_ZERO, lvl: IN_ZERO};

endpackage

/* File: cpm_sync.sv */
// Three-stage input synchroniser with agreement filter and edge detection.
`timescale 1ns/1ns
module cpm_sync (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [cpm_pkg::N_IN-1:0] raw,
    output cpm_pkg::cpm_edges_t edges
);

    cpm_pkg::cpm_sync_t st;
    cpm_pkg::cpm_sync_t next_st;
    logic [cpm_pkg::N_IN-1:0] agree;

    // ----------------------------------------------------------------
    // Filter
    // ----------------------------------------------------------------
    // The first stage feeds only the second; the level moves once the
    // second and third stages agree, so each pin edge yields one pulse.
    always_comb begin
        agree = ~(st.s2 ^ st.s3);
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = (agree & st.s3) | (~agree & st.lvl); // see [RULE_16]
        edges.lvl = st.lvl;
        edges.rise = agree & st.s3 & ~st.lvl; // see [RULE_16]
        edges.fall = agree & ~st.s3 & st.lvl; // see [RULE_16]
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st <= cpm_pkg::SYNC_RST;
        end else begin
            st <= next_st;
        end
    end

endmodule

/* File: cpm_meter.sv */
// Counter for gate period and encoder position, with a two-entry result buffer.
`timescale 1ns/1ns
module cpm_meter (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic ARM,
    input wire logic READ_REQ,
    input wire cpm_pkg::cpm_cfg_t CFG,
    input wire logic GATE_IN,
    input wire logic SOURCE_IN,
    input wire logic ENC_A,
    input wire logic ENC_B,
    input wire logic ENC_Z,
    input wire logic OUT_READY,
    output logic [cpm_pkg::CNT_W-1:0] COUNT,
    output logic ARMED,
    output logic DONE,
    output logic OVERRUN,
    output logic OUT_VALID,
    output logic [cpm_pkg::CNT_W-1:0] OUT_DATA
);

    cpm_pkg::cpm_edges_t e;
    cpm_pkg::cpm_core_t st;
    cpm_pkg::cpm_core_t next_st;
    logic gate_edge;
    logic samp_edge;
    logic src_edge;
    logic a;
    logic b;
    logic ar;
    logic af;
    logic br;
    logic bf;
    logic up;
    logic dn;
    logic both_move;
    logic reload_hit;
    logic push;
    logic pop;
    logic [cpm_pkg::CNT_W-1:0] push_data;

    function automatic logic pick_edge(input logic use_fall, input logic r, input logic f);
        return use_fall ? f : r;
    endfunction

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    cpm_sync u_sync (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .raw({ENC_Z, ENC_B, ENC_A, SOURCE_IN, GATE_IN}), // see [RULE_07] [RULE_16]
        .edges(e)
    );

    // ----------------------------------------------------------------
    // Edge selection and quadrature decode
    // ----------------------------------------------------------------
    always_comb begin
        gate_edge = pick_edge(CFG.gate_fall, e.rise[cpm_pkg::IX_GATE],
                              e.fall[cpm_pkg::IX_GATE]); // see [RULE_02]
        samp_edge = pick_edge(CFG.sample_fall, e.rise[cpm_pkg::IX_GATE],
                              e.fall[cpm_pkg::IX_GATE]);
        src_edge = pick_edge(CFG.src_fall, e.rise[cpm_pkg::IX_SRC],
                             e.fall[cpm_pkg::IX_SRC]); // see [RULE_03]
        a = e.lvl[cpm_pkg::IX_A];
        b = e.lvl[cpm_pkg::IX_B];
        ar = e.rise[cpm_pkg::IX_A];
        af = e.fall[cpm_pkg::IX_A];
        br = e.rise[cpm_pkg::IX_B];
        bf = e.fall[cpm_pkg::IX_B];
        // A and B moving in one cycle gives no direction; such steps are dropped except in two-pulse decode
        both_move = (ar | af) & (br | bf);
        up = 1'b0;
        dn = 1'b0;
        unique case (CFG.decode) // see [RULE_06]
            cpm_pkg::DEC_X1: begin
                up = ar & ~b; // see [RULE_08]
                dn = af & ~b; // see [RULE_09]
            end
            cpm_pkg::DEC_X2: begin
                up = (ar & ~b) | (af & b); // see [RULE_10]
                dn = (ar & b) | (af & ~b);
            end
            cpm_pkg::DEC_X4: begin
                up = (ar & ~b) | (af & b) | (br & a) | (bf & ~a); // see [RULE_11]
                dn = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);
            end
            cpm_pkg::DEC_TWO: begin
                up = ar; // see [RULE_14]
                dn = br;
            end
        endcase
        if (both_move && CFG.decode != cpm_pkg::DEC_TWO) begin
            up = 1'b0;
            dn = 1'b0;
        end
        reload_hit = CFG.z_enable & e.lvl[cpm_pkg::IX_Z]
                     & ({a, b} == CFG.z_phase); // see [RULE_12]
    end

    // ----------------------------------------------------------------
    // Counter state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        push = 1'b0;
        push_data = st.cnt;
        pop = st.v[0] & OUT_READY;
        if (ARM) begin
            next_st.cnt = cpm_pkg::CNT_ZERO; // see [RULE_17]
            next_st.busy = 1'b1;
            next_st.done = 1'b0;
            next_st.ovr = 1'b0;
            next_st.state = (CFG.mode == cpm_pkg::MODE_POS) ? cpm_pkg::ST_MEAS
                                                            : cpm_pkg::ST_WAIT;
        end else begin
            unique case (st.state)
                cpm_pkg::ST_IDLE: begin
                    next_st.state = cpm_pkg::ST_IDLE; // see [RULE_04]
                end
                cpm_pkg::ST_WAIT: begin
                    if (gate_edge) begin
                        next_st.state = cpm_pkg::ST_MEAS; // see [RULE_01]
                    end
                end
                cpm_pkg::ST_MEAS: begin
                    if (CFG.mode == cpm_pkg::MODE_PERIOD) begin
                        if (gate_edge) begin
                            push = 1'b1; // see [RULE_01]
                            next_st.state = cpm_pkg::ST_DONE;
                            next_st.busy = 1'b0;
                            next_st.done = 1'b1;
                        end else if (src_edge) begin
                            next_st.cnt = st.cnt + cpm_pkg::CNT_ONE; // see [RULE_03]
                        end
                    end else begin
                        // A step outranks the reload; the reload follows a
                        // cycle later while the phase still holds
                        if (up && !dn) begin
                            next_st.cnt = st.cnt + cpm_pkg::CNT_ONE; // see [RULE_13]
                        end else if (dn && !up) begin
                            next_st.cnt = st.cnt - cpm_pkg::CNT_ONE;
                        end else if (reload_hit && !up && !dn) begin
                            next_st.cnt = CFG.reload; // see [RULE_12] [RULE_13]
                        end
                        if (CFG.buffered && samp_edge) begin
                            push = 1'b1; // see [RULE_05] [RULE_15]
                        end
                    end
                end
                cpm_pkg::ST_DONE: begin
                    next_st.state = cpm_pkg::ST_DONE;
                end
            endcase
        end
        // On-demand read; refused while a sample-clocked capture runs
        if (!push && READ_REQ && !ARM
            && !(st.busy && CFG.mode == cpm_pkg::MODE_POS && CFG.buffered)) begin
            push = 1'b1; // see [RULE_05]
        end

        // ------------------------------------------------------------
        // Two-entry result buffer
        // ------------------------------------------------------------
        if (pop) begin
            next_st.ent[0] = st.ent[1];
            next_st.v = {1'b0, st.v[1]};
        end
        if (push) begin
            if (!next_st.v[0]) begin
                next_st.ent[0] = push_data;
                next_st.v[0] = 1'b1;
            end else if (!next_st.v[1]) begin
                next_st.ent[1] = push_data;
                next_st.v[1] = 1'b1;
            end else begin
                // Set after the arm clear so a loss in that cycle is kept
                next_st.ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st.state <= cpm_pkg::ST_IDLE;
            st.busy <= 1'b0;
            st.done <= 1'b0;
            st.ovr <= 1'b0;
            st.cnt <= cpm_pkg::CNT_ZERO;
            st.v <= {cpm_pkg::BUF_N{1'b0}};
            st.ent <= {cpm_pkg::BUF_N{cpm_pkg::CNT_ZERO}};
        end else begin
            st <= next_st;
        end
    end

    assign COUNT = st.cnt;
    assign ARMED = st.busy;
    assign DONE = st.done;
    assign OVERRUN = st.ovr;
    assign OUT_VALID = st.v[0];
    assign OUT_DATA = st.ent[0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    arm_clear_a: assert property (ARM |=> COUNT == cpm_pkg::CNT_ZERO ##1 ARMED) // see [RULE_17]
        else $error("count not cleared by arm");
    idle_hold_a: assert property (st.state == cpm_pkg::ST_IDLE && !ARM
                                  |=> $stable(COUNT)) // see [RULE_04]
        else $error("count moved before arm");
    period_end_a: assert property (!ARM && st.state == cpm_pkg::ST_MEAS
                                   && CFG.mode == cpm_pkg::MODE_PERIOD && gate_edge
                                   |=> DONE && !ARMED && st.state == cpm_pkg::ST_DONE) // see [RULE_01]
        else $error("period did not close on gate edge");
    src_count_a: assert property (!ARM && st.state == cpm_pkg::ST_MEAS
                                  && CFG.mode == cpm_pkg::MODE_PERIOD
                                  && !gate_edge && src_edge
                                  |=> COUNT == $past(COUNT) + cpm_pkg::CNT_ONE) // see [RULE_03]
        else $error("source edge not counted");
    x1_up_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                              && CFG.decode == cpm_pkg::DEC_X1 && ar && !b && !br && !bf
                              |=> COUNT == $past(COUNT) + cpm_pkg::CNT_ONE) // see [RULE_08]
        else $error("single count increment missed");
    x1_down_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                                && CFG.decode == cpm_pkg::DEC_X1 && af && !b && !br && !bf
                                |=> COUNT == $past(COUNT) - cpm_pkg::CNT_ONE) // see [RULE_09]
        else $error("single count decrement missed");
    x4_b_up_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                                && CFG.decode == cpm_pkg::DEC_X4 && br && a && !ar && !af
                                |=> COUNT == $past(COUNT) + cpm_pkg::CNT_ONE) // see [RULE_11]
        else $error("quadruple count B edge missed");
    two_down_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                                 && CFG.decode == cpm_pkg::DEC_TWO && br && !ar
                                 |=> COUNT == $past(COUNT) - cpm_pkg::CNT_ONE) // see [RULE_14]
        else $error("two-pulse decrement missed");
    index_load_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                                   && reload_hit && !up && !dn
                                   |=> COUNT == $past(CFG.reload)) // see [RULE_12]
        else $error("index reload missed");
    sample_keep_a: assert property (!ARM && ARMED && CFG.mode == cpm_pkg::MODE_POS
                                    && CFG.buffered && samp_edge && !OUT_VALID
                                    |=> OUT_VALID && OUT_DATA == $past(COUNT)
                                        && ARMED) // see [RULE_15]
        else $error("sample not captured");

endmodule

/* File: cpm_enc_model.sv */
// Behavioural encoder, gate and source pins driven into the meter.
`timescale 1ns/1ns
module cpm_enc_model (
    input wire logic clk,
    output logic gate,
    output logic src,
    output logic enc_a,
    output logic enc_b,
    output logic enc_z
);
    logic [1:0] ab = 2'h0;
    assign {enc_a, enc_b} = ab;
    initial {gate, src, enc_z} = 3'h0;
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Every level held 4 cycles: the input filter needs 2 to see it once
    task automatic quad(input bit fwd, input int steps);
        repeat (steps) begin
            ab <= fwd ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
            hold(4);
        end
    endtask
    task automatic pulse(input bit on_b);
        ab <= on_b ? 2'h1 : 2'h2;
        hold(4);
        ab <= 2'h0;
        hold(4);
    endtask
    task automatic spulse(input int n);
        repeat (n) begin
            src <= 1'b1;
            hold(4);
            src <= 1'b0;
            hold(4);
        end
    endtask
    // Source pulses also before the first active edge; they must not count
    task automatic gate_period(input bit act, input int n);
        gate <= ~act;
        spulse(2);
        gate <= act;
        hold(2);
        spulse(1);
        gate <= ~act;
        spulse(n - 1);
        hold(2);
        gate <= act;
        hold(4);
        gate <= ~act;
        hold(4);
    endtask
    // Starts low so both a rise and a fall follow whatever level came before
    task automatic samp;
        gate <= 1'b0;
        hold(4);
        gate <= 1'b1;
        hold(4);
        gate <= 1'b0;
        hold(6);
    endtask
    task automatic zset(input bit v);
        enc_z <= v;
    endtask
endmodule

/* File: test_counter_period_position_meter.sv */
// Self-checking bench for the counter period and position meter.
`timescale 1ns/1ns
module test_counter_period_position_meter;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic arm = 1'b0;
    logic read_req = 1'b0;
    logic out_ready = 1'b0;
    logic stall = 1'b0;
    cpm_pkg::cpm_cfg_t cfg = '0;
    logic gate, src, enc_a, enc_b, enc_z;
    logic [cpm_pkg::CNT_W-1:0] count, out_data, rl, snap;
    logic armed, done, overrun, out_valid;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int compares = 0;
    int seed = 32'h599D4DB0;

    always #50 core_clk = ~core_clk;

    cpm_meter u_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .ARM(arm), .READ_REQ(read_req),
        .CFG(cfg), .GATE_IN(gate), .SOURCE_IN(src), .ENC_A(enc_a), .ENC_B(enc_b),
        .ENC_Z(enc_z), .OUT_READY(out_ready), .COUNT(count), .ARMED(armed), .DONE(done),
        .OVERRUN(overrun), .OUT_VALID(out_valid), .OUT_DATA(out_data));
    cpm_enc_model u_enc (.clk(core_clk), .gate(gate), .src(src), .enc_a(enc_a),
        .enc_b(enc_b), .enc_z(enc_z));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse_arm;
        arm <= 1'b1;
        cyc(1);
        arm <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [31:0] e, input bit expect_word);
        if (expect_word) exp_q.push_back(e);
        read_req <= 1'b1;
        cyc(1);
        read_req <= 1'b0;
        cyc(1);
    endtask
    task automatic drain;
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) cyc(1);
        check(exp_q.size(), 0);
    endtask
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Consumer and result monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk) out_ready <= stall ? 1'b0 : 1'($random(seed));
    always @(posedge core_clk) begin
        if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("MISMATCH at %0t: unexpected word %h", $time, out_data);
            end else begin
                check(out_data, exp_q.pop_front());
            end
        end
    end

    initial begin
        cyc(20000);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rl = $random(seed);
        cyc(6);
        sys_rst <= 1'b0;
        cyc(2);
        check(count, 0);
        check({armed, done, overrun, out_valid}, 0);
        for (int i = 0; i < 4; i++) begin
            cfg.gate_fall <= i[0];
            cfg.src_fall <= i[1];
            cyc(1);
            pulse_arm();
            check(count, 0);
            check(armed, 1);
            exp_q.push_back(3 + i);
            u_enc.gate_period(!i[0], 3 + i);
            cyc(4);
            check(done, 1);
            check(armed, 0);
        end
        drain();
        $display("period tests done");
        cfg <= '0;
        cfg.mode <= cpm_pkg::MODE_POS;
        cyc(1);
        snap = count;
        u_enc.quad(1, 4);
        cyc(6);
        check(count, snap);
        for (int d = 0; d < 3; d++) begin
            cfg.decode <= cpm_pkg::cpm_decode_t'(d);
            pulse_arm();
            u_enc.quad(1, 8);
            cyc(6);
            check(count, 2 << d);
            u_enc.quad(0, 4);
            cyc(6);
            check(count, 1 << d);
            rd(1 << d, 1);
        end
        cfg.decode <= cpm_pkg::DEC_TWO;
        pulse_arm();
        repeat (3) u_enc.pulse(0);
        u_enc.pulse(1);
        cyc(4);
        check(count, 2);
        cfg.decode <= cpm_pkg::DEC_X4;
        cfg.z_enable <= 1'b1;
        cfg.z_phase <= 2'h3;
        cfg.reload <= rl;
        pulse_arm();
        u_enc.quad(1, 1);
        u_enc.zset(1);
        u_enc.quad(1, 1);
        u_enc.zset(0);
        cyc(4);
        check(count, rl);
        u_enc.quad(1, 4);
        cyc(6);
        check(count, rl + 4);
        $display("position tests done");
        cfg.decode <= cpm_pkg::DEC_X1;
        cfg.z_enable <= 1'b0;
        cfg.buffered <= 1'b1;
        pulse_arm();
        for (int s = 1; s < 3; s++) begin
            // First sample on the rising gate edge, second on the falling one
            cfg.sample_fall <= s[1];
            u_enc.quad(1, 4);
            exp_q.push_back(s);
            u_enc.samp();
        end
        rd(0, 0);
        drain();
        cfg.buffered <= 1'b0;
        pulse_arm();
        stall <= 1'b1;
        cyc(2);
        rd(0, 1);
        rd(0, 1);
        rd(0, 0);
        cyc(2);
        check({overrun, out_valid}, 2'h3);
        stall <= 1'b0;
        drain();
        cyc(2);
        pulse_arm();
        check(overrun, 0);
        $display("buffer tests done");
        stop_test();
    end
endmodule
